// File: dv/ipbi_far_model.sv
module ipbi_far_model
  import ipbi_pkg::*;
(
  input  wire logic        sys_clk_i,   // core clock
  input  wire logic        reset_i,     // sync reset, high
  input  wire logic        miss_go_i,   // start a fetch miss
  input  wire logic        slip_go_i,   // start a data-side slip
  input  wire logic [3:0]  wait_len_i,  // cycles the event lasts
  output logic             miss_o,      // fetch missed
  output logic             fill_o,      // refill word valid
  output ipbi_word_t       word_o,      // refill word
  output logic             dslip_o      // data-side slip cause
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam ipbi_word_t FILL_WORD = 32'h5a5a_0f0f;
  logic [3:0] mcnt_reg;
  logic [3:0] scnt_reg;
  logic [7:0] cyc_reg;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cyc_reg  <= 8'h00;
      mcnt_reg <= 4'h0;
      scnt_reg <= 4'h0;
      fill_o   <= 1'b0;
    end else begin
      cyc_reg <= cyc_reg + 8'h01;
      fill_o <= (mcnt_reg == 4'h1);
      mcnt_reg <= miss_go_i ? wait_len_i : mcnt_reg - 4'((mcnt_reg != 4'h0));
      scnt_reg <= slip_go_i ? wait_len_i : scnt_reg - 4'((scnt_reg != 4'h0));
    end
  end
  assign miss_o  = (mcnt_reg != 4'h0);
  assign dslip_o = (scnt_reg != 4'h0);
  // word is junk outside the fill pulse
  assign word_o  = fill_o ? FILL_WORD : {4{cyc_reg}};
endmodule

// File: dv/tb_integer_pipe_bypass_interlock.sv
module tb_integer_pipe_bypass_interlock;
  timeunit 1ns;
  timeprecision 1ps;
  import ipbi_pkg::*;
  localparam ipbi_word_t M_VAL = 32'h1111_aaaa;
  localparam ipbi_word_t A_VAL = 32'h2222_bbbb;
  localparam ipbi_word_t RA    = 32'h3333_cccc;
  localparam ipbi_word_t RB    = 32'h4444_dddd;
  localparam ipbi_word_t FILLW = 32'h5a5a_0f0f;
  localparam ipbi_word_t W_VAL = 32'h5555_eeee;
  localparam logic [5:0] K_ALU = 6'h00, K_USE = 6'h30, K_LD = 6'h08, K_MV = 6'h04;
  localparam logic [5:0] K_MLH = 6'h02, K_MLF = 6'h03;
  logic       sys_clk, reset, i_valid, i_use_a, i_use_b, i_is_load, i_is_move;
  logic       i_is_mul, i_mul_full, miss_go, slip_go, miss, fill, dslip;
  logic       adv_i, adv_e, adv_m, adv_a, e_bubble, w_we;
  logic [3:0] wait_len;
  ipbi_reg_t  i_src_a, i_src_b, i_dst, w_dst;
  ipbi_word_t fword, op_a, op_b, e_fill;
  int         fail_count, total_checks, waits, bubbles, amlow, fills, cycles;

  ipbi_pipe_ctrl ipbi_pipe_ctrl_i (.sys_clk_i(sys_clk), .reset_i(reset), .i_valid_i(i_valid),
    .i_src_a_i(i_src_a), .i_src_b_i(i_src_b), .i_use_a_i(i_use_a), .i_use_b_i(i_use_b),
    .i_dst_i(i_dst), .i_is_load_i(i_is_load), .i_is_move_i(i_is_move), .i_is_mul_i(i_is_mul),
    .i_mul_full_i(i_mul_full), .icache_miss_i(miss), .icache_fill_i(fill), .fill_word_i(fword),
    .dside_slip_i(dslip), .m_result_i(M_VAL), .a_result_i(A_VAL), .rf_rd_a_i(RA),
    .rf_rd_b_i(RB), .w_data_i(W_VAL), .op_a_o(op_a), .op_b_o(op_b),
    .e_fill_word_o(e_fill), .adv_i_o(adv_i), .adv_e_o(adv_e), .adv_m_o(adv_m),
    .adv_a_o(adv_a), .e_bubble_o(e_bubble), .w_we_o(w_we), .w_dst_o(w_dst));
  ipbi_far_model ipbi_far_model_i (.sys_clk_i(sys_clk), .reset_i(reset), .miss_go_i(miss_go),
    .slip_go_i(slip_go), .wait_len_i(wait_len), .miss_o(miss), .fill_o(fill), .word_o(fword),
    .dslip_o(dslip));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      $display("[ERR] %0t run hung", $time);
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    {i_valid, i_use_a, i_use_b, i_is_load, i_is_move, i_is_mul, i_mul_full} = '0;
    {i_src_a, i_src_b, i_dst} = '0;
    repeat (n) @(negedge sys_clk);
    {waits, bubbles, amlow, fills} = '0;
  endtask
  // holds one instruction in I until taken, tallying slips on the way
  task automatic issue(input ipbi_reg_t a, input ipbi_reg_t b, input ipbi_reg_t d,
                       input logic [5:0] k);
    {i_use_a, i_use_b, i_is_load, i_is_move, i_is_mul, i_mul_full} = k;
    {i_valid, i_src_a, i_src_b, i_dst} = {1'b1, a, b, d};
    for (int n = 0; n < 20; n++) begin
      @(negedge sys_clk);
      miss_go = 1'b0;
      slip_go = 1'b0;
      bubbles += int'(e_bubble === 1'b1);
      fills += int'(e_fill === FILLW);
      if (adv_m === 1'b0) begin
        amlow++;
        check({adv_e, adv_i}, 2'h0);
      end
      check(adv_a, 1'b1);
      if (adv_i === 1'b1) break;
      waits++;
    end
  endtask
  // producer, gap fillers, consumer of s, then fillers; counts the slip
  task automatic slip_test(input logic [5:0] k, input ipbi_reg_t d, input int gap,
                           input ipbi_reg_t s, input int exp);
    issue(5'h00, 5'h00, d, k);
    repeat (gap) issue(5'h00, 5'h00, 5'h0f, K_ALU);
    issue(s, 5'h00, 5'h0e, K_USE);
    repeat (4) issue(5'h00, 5'h00, 5'h0d, K_ALU);
    check(32'(waits), 32'(exp));
    check(32'(bubbles), 32'(exp));
    check(32'(amlow), 32'h0);
    $display("slip test k=%h gap=%0d done", k, gap);
    idle(6);
  endtask
  // two producers then a consumer; looks for the expected operand pair
  task automatic fwd(input logic [5:0] k1, input ipbi_reg_t d1, input logic [5:0] k2,
                     input ipbi_reg_t d2, input ipbi_reg_t sa, input ipbi_reg_t sb,
                     input ipbi_word_t ea, input ipbi_word_t eb);
    issue(5'h00, 5'h00, d1, k1);
    issue(5'h00, 5'h00, d2, k2);
    issue(sa, sb, 5'h0b, K_USE);
    i_valid = 1'b0;
    // operands judged at the edge where the consumer leaves E
    for (int n = 0; n < 6; n++) begin
      @(negedge sys_clk);
      if (adv_e === 1'b1) break;
    end
    check(op_a, ea);
    check(op_b, eb);
    $display("forward test %0d %0d done", sa, sb);
    idle(6);
  endtask
  // producer three ahead of its consumer, met by the write-port bypass
  task automatic wb_test();
    issue(5'h00, 5'h00, 5'h07, K_ALU);
    repeat (2) issue(5'h00, 5'h00, 5'h0f, K_ALU);
    issue(5'h07, 5'h00, 5'h0e, K_USE);
    i_valid = 1'b0;
    check({w_we, w_dst}, {1'b1, 5'h07});
    @(negedge sys_clk);
    check(op_a, W_VAL);
    check(op_b, RB);
    $display("write bypass test done");
    idle(6);
  endtask
  task automatic far_test(input logic is_miss);
    {miss_go, slip_go} = {is_miss, !is_miss};
    repeat (8) issue(5'h00, 5'h00, 5'h0c, K_ALU);
    if (is_miss) begin
      check(fills != 0, 1'b1);
      check(32'(waits), 32'(wait_len) + 32'h1);
      check(e_fill, FILLW);
    end else
      check(32'(amlow), 32'h3);
    $display("far side test %0d done", is_miss);
    idle(6);
  endtask

  initial begin
    {reset, miss_go, slip_go, wait_len} = {3'b100, 4'h3};
    idle(6);
    check({adv_i, adv_e, adv_m, e_bubble, w_we}, 5'h00);
    check(op_a, 32'h0);
    reset = 1'b0;
    idle(4);
    slip_test(K_LD, 5'h05, 0, 5'h05, 1);
    slip_test(K_LD, 5'h05, 1, 5'h05, 0);
    slip_test(K_MV, 5'h05, 0, 5'h05, 1);
    slip_test(K_LD, 5'h00, 0, 5'h00, 0);
    slip_test(K_MLH, 5'h06, 0, 5'h06, 2);
    slip_test(K_MLF, 5'h06, 0, 5'h06, 3);
    slip_test(K_MLH, 5'h06, 0, 5'h09, 1);
    slip_test(K_MLF, 5'h06, 0, 5'h09, 2);
    slip_test(K_ALU, 5'h05, 0, 5'h05, 0);
    fwd(K_ALU, 5'h09, K_ALU, 5'h01, 5'h01, 5'h02, M_VAL, RB);
    fwd(K_ALU, 5'h09, K_ALU, 5'h01, 5'h03, 5'h01, RA, M_VAL);
    fwd(K_ALU, 5'h01, K_ALU, 5'h02, 5'h01, 5'h02, A_VAL, M_VAL);
    fwd(K_ALU, 5'h01, K_ALU, 5'h01, 5'h01, 5'h02, M_VAL, RB);
    fwd(K_LD, 5'h04, K_ALU, 5'h09, 5'h04, 5'h02, A_VAL, RB);
    fwd(K_ALU, 5'h09, K_MV, 5'h01, 5'h01, 5'h02, A_VAL, RB);
    fwd(K_ALU, 5'h09, K_ALU, 5'h00, 5'h00, 5'h02, RA, RB);
    wb_test();
    far_test(1'b0);
    far_test(1'b1);
    test_done();
  end
endmodule

// File: hw/ipbi_pipe_ctrl.sv
// How it works
// RULE1: both source operands are read from the register file early in E.
// RULE2: ALU result ready in M, written in W; forwarding hides the gap.
// RULE3: each ALU operand has a mux fed by M-to-E and A-to-E paths.
// RULE4: no W-to-E path; register file returns write data on same-cycle reads.
// RULE5: two operands from A and M producers are forwarded at once.
// RULE6: consumer directly after a load slips one cycle in E.
// RULE7: consumer two after a load takes the A-to-E path without slip.
// RULE8: move-from-high/low/system results enter in A; next consumer slips one.
// RULE9: all interlock conditions are checked each cycle for every stage.
// RULE10: data-side conditions slip the late pipeline.
// RULE11: every interlock is a slip, never a full stall.
// RULE12: per-stage advance; a held stage holds every younger stage.
// RULE13: slipped instruction retried each cycle; NOP bubbles fill downstream.
// RULE14: fetch miss advances to E, waits for fill, refill word forwarded.
// RULE15: one issue per clock unless a result is not yet available.
// RULE16: fast multiply delays consumer 2/3, non-consumer 1/2 by width.
// RULE17: when M and A both write the source, the younger M result wins.
// RULE18: destination register zero is never treated as a producer.
`include "ipbi_map.svh"
module ipbi_pipe_ctrl
  import ipbi_pkg::*;
(
  input  wire logic        sys_clk_i,        // core clock
  input  wire logic        reset_i,          // sync reset, high
  input  wire logic        i_valid_i,        // instruction in I
  input  wire logic [4:0]  i_src_a_i,        // I source a
  input  wire logic [4:0]  i_src_b_i,        // I source b
  input  wire logic        i_use_a_i,        // I reads source a
  input  wire logic        i_use_b_i,        // I reads source b
  input  wire logic [4:0]  i_dst_i,          // I destination
  input  wire logic        i_is_load_i,      // I is a load
  input  wire logic        i_is_move_i,      // I is move from high/low/system
  input  wire logic        i_is_mul_i,       // I is three-operand multiply
  input  wire logic        i_mul_full_i,     // multiply full-width operands
  input  wire logic        icache_miss_i,    // fetch missed in I
  input  wire logic        icache_fill_i,    // refill word returning
  input  wire logic [31:0] fill_word_i,      // refill instruction word
  input  wire logic        dside_slip_i,     // any data-side slip cause
  input  wire logic [31:0] m_result_i,       // ALU result in M
  input  wire logic [31:0] a_result_i,       // aligned/moved result in A
  input  wire logic [31:0] rf_rd_a_i,        // register file port a
  input  wire logic [31:0] rf_rd_b_i,        // register file port b
  input  wire logic [31:0] w_data_i,         // W write data
  output logic      [31:0] op_a_o,           // forwarded operand a
  output logic      [31:0] op_b_o,           // forwarded operand b
  output logic      [31:0] e_fill_word_o,    // refill word to E
  output logic             adv_i_o,          // I advances
  output logic             adv_e_o,          // E advances
  output logic             adv_m_o,          // M advances
  output logic             adv_a_o,          // A advances
  output logic             e_bubble_o,       // NOP into M
  output logic             w_we_o,           // register write in W
  output logic      [4:0]  w_dst_o           // W destination
);
  // per-stage tag registers
  logic        e_v_reg, m_v_reg, a_v_reg, w_v_reg;
  logic        e_v_next, m_v_next, a_v_next, w_v_next;
  ipbi_reg_t   e_sa_reg, e_sb_reg, e_d_reg, m_d_reg, a_d_reg, w_d_reg;
  ipbi_reg_t   e_sa_next, e_sb_next, e_d_next, m_d_next, a_d_next, w_d_next;
  logic        e_ua_reg, e_ub_reg, e_ua_next, e_ub_next;
  logic        e_late_reg, m_late_reg, e_late_next, m_late_next;
  logic        e_mul_reg, e_mulf_reg, e_mul_next, e_mulf_next;
  logic [1:0]  mul_cnt_reg, mul_cnt_next;
  ipbi_fetch_t fetch_reg, fetch_next;
  logic [31:0] fill_reg, fill_next;
  logic [31:0] op_a_reg, op_b_reg, op_a_next, op_b_next;
  logic        adv_i_reg, adv_e_reg, adv_m_reg, adv_a_reg, bub_reg;
  logic        adv_i_next, adv_e_next, adv_m_next, adv_a_next, bub_next;

  logic      m_wr, a_wr, w_wr, late_hit, mul_hit, fetch_wait, hold_m, hold_e;
  ipbi_sel_t sel_a, sel_b;
  logic      adv_m, adv_e, adv_i;

  function automatic ipbi_sel_t pick(input ipbi_reg_t src, input logic mw, input logic aw);
    if (mw && src == m_d_reg) begin                                     // RULE17
      pick = IPBI_SEL_M;
    end else if (aw && src == a_d_reg) begin
      pick = IPBI_SEL_A;
    end else begin
      pick = IPBI_SEL_FILE;
    end
  endfunction

  function automatic logic [31:0] rf_read(input ipbi_reg_t src, input logic [31:0] rf);
    if (w_wr && src == w_d_reg) begin                                   // RULE4
      rf_read = w_data_i;
    end else begin
      rf_read = rf;
    end
  endfunction

  // hazard evaluation, every cycle
  always_comb begin
    m_wr = m_v_reg && m_d_reg != `IPBI_ZERO_REG;                        // RULE18
    a_wr = a_v_reg && a_d_reg != `IPBI_ZERO_REG;
    w_wr = w_v_reg;
    late_hit = e_v_reg && m_wr && m_late_reg &&                         // RULE6 RULE8 RULE9
               ((e_ua_reg && e_sa_reg == m_d_reg) || (e_ub_reg && e_sb_reg == m_d_reg));
    mul_hit = e_v_reg && mul_cnt_reg != 2'h0;                           // RULE16
    fetch_wait = fetch_reg != IPBI_FETCH_RUN;                           // RULE14
    hold_m = dside_slip_i;                                              // RULE10
    hold_e = late_hit || mul_hit || fetch_wait;
    adv_m = !hold_m;                                                    // RULE11
    adv_e = adv_m && !hold_e;                                           // RULE12
    adv_i = adv_e;
    sel_a = pick(e_sa_reg, m_wr && !m_late_reg, a_wr);                  // RULE3 RULE5 RULE7
    sel_b = pick(e_sb_reg, m_wr && !m_late_reg, a_wr);
  end

  // operand muxes
  always_comb begin
    unique case (sel_a)
      IPBI_SEL_M: op_a_next = m_result_i;                               // RULE2
      IPBI_SEL_A: op_a_next = a_result_i;
      default:    op_a_next = rf_read(e_sa_reg, rf_rd_a_i);              // RULE1
    endcase
    unique case (sel_b)
      IPBI_SEL_M: op_b_next = m_result_i;
      IPBI_SEL_A: op_b_next = a_result_i;
      default:    op_b_next = rf_read(e_sb_reg, rf_rd_b_i);
    endcase
  end

  // stage advance and bubble insertion
  always_comb begin
    e_v_next = e_v_reg;
    e_sa_next = e_sa_reg;
    e_sb_next = e_sb_reg;
    e_d_next = e_d_reg;
    e_ua_next = e_ua_reg;
    e_ub_next = e_ub_reg;
    e_late_next = e_late_reg;
    e_mul_next = e_mul_reg;
    e_mulf_next = e_mulf_reg;
    m_v_next = m_v_reg;
    m_d_next = m_d_reg;
    m_late_next = m_late_reg;
    if (adv_i) begin                                                    // RULE15
      e_v_next = i_valid_i;
      e_sa_next = i_src_a_i;
      e_sb_next = i_src_b_i;
      e_d_next = i_dst_i;
      e_ua_next = i_use_a_i;
      e_ub_next = i_use_b_i;
      e_late_next = i_is_load_i || i_is_move_i;
      e_mul_next = i_is_mul_i;
      e_mulf_next = i_mul_full_i;
    end
    if (adv_e) begin
      m_v_next = e_v_reg;
      m_d_next = e_d_reg;
      m_late_next = e_late_reg;
    end else if (adv_m) begin
      m_v_next = 1'b0;                                                  // RULE13
    end
    a_v_next = adv_m && m_v_reg;                                        // RULE13
    a_d_next = adv_m ? m_d_reg : a_d_reg;
    w_v_next = a_wr;                                                    // RULE18
    w_d_next = a_d_reg;
  end

  // multiply issue delay, counts down on every cycle that M advances, even while E is held for another cause
  always_comb begin
    mul_cnt_next = mul_cnt_reg;
    if (mul_cnt_reg != 2'h0 && adv_m) begin
      mul_cnt_next = mul_cnt_reg - 2'h1;
    end
    if (adv_e && e_v_reg && e_mul_reg) begin
      if (i_valid_i && e_d_reg != `IPBI_ZERO_REG &&
          ((i_use_a_i && i_src_a_i == e_d_reg) || (i_use_b_i && i_src_b_i == e_d_reg))) begin
        mul_cnt_next = e_mulf_reg ? `IPBI_MUL_USE_FULL : `IPBI_MUL_USE_HALF;
      end else begin
        mul_cnt_next = e_mulf_reg ? `IPBI_MUL_NOUSE_FULL : `IPBI_MUL_NOUSE_HALF;
      end
    end
  end

  // fetch miss: instruction waits in E for the fill
  always_comb begin
    fetch_next = fetch_reg;
    fill_next = fill_reg;
    unique case (fetch_reg)
      IPBI_FETCH_RUN:  if (icache_miss_i && adv_i) fetch_next = IPBI_FETCH_MISS;
      IPBI_FETCH_MISS: if (icache_fill_i) begin
        fetch_next = IPBI_FETCH_FILL;
        fill_next = fill_word_i;                                        // RULE14
      end
      IPBI_FETCH_FILL: fetch_next = IPBI_FETCH_RUN;
      default:         fetch_next = IPBI_FETCH_RUN;
    endcase
    adv_i_next = adv_i;
    adv_e_next = adv_e;
    adv_m_next = adv_m;
    adv_a_next = 1'b1;
    bub_next = adv_m && !adv_e;
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      e_v_reg <= 1'b0;
      m_v_reg <= 1'b0;
      a_v_reg <= 1'b0;
      w_v_reg <= 1'b0;
      e_sa_reg <= 5'h00;
      e_sb_reg <= 5'h00;
      e_d_reg <= 5'h00;
      m_d_reg <= 5'h00;
      a_d_reg <= 5'h00;
      w_d_reg <= 5'h00;
      e_ua_reg <= 1'b0;
      e_ub_reg <= 1'b0;
      e_late_reg <= 1'b0;
      m_late_reg <= 1'b0;
      e_mul_reg <= 1'b0;
      e_mulf_reg <= 1'b0;
      mul_cnt_reg <= 2'h0;
      fetch_reg <= IPBI_FETCH_RUN;
      fill_reg <= 32'h0000_0000;
      op_a_reg <= 32'h0000_0000;
      op_b_reg <= 32'h0000_0000;
      adv_i_reg <= 1'b0;
      adv_e_reg <= 1'b0;
      adv_m_reg <= 1'b0;
      adv_a_reg <= 1'b0;
      bub_reg <= 1'b0;
    end else begin
      e_v_reg <= e_v_next;
      m_v_reg <= m_v_next;
      a_v_reg <= a_v_next;
      w_v_reg <= w_v_next;
      e_sa_reg <= e_sa_next;
      e_sb_reg <= e_sb_next;
      e_d_reg <= e_d_next;
      m_d_reg <= m_d_next;
      a_d_reg <= a_d_next;
      w_d_reg <= w_d_next;
      e_ua_reg <= e_ua_next;
      e_ub_reg <= e_ub_next;
      e_late_reg <= e_late_next;
      m_late_reg <= m_late_next;
      e_mul_reg <= e_mul_next;
      e_mulf_reg <= e_mulf_next;
      mul_cnt_reg <= mul_cnt_next;
      fetch_reg <= fetch_next;
      fill_reg <= fill_next;
      op_a_reg <= op_a_next;
      op_b_reg <= op_b_next;
      adv_i_reg <= adv_i_next;
      adv_e_reg <= adv_e_next;
      adv_m_reg <= adv_m_next;
      adv_a_reg <= adv_a_next;
      bub_reg <= bub_next;
    end
  end

  assign op_a_o = op_a_reg;
  assign op_b_o = op_b_reg;
  assign e_fill_word_o = fill_reg;
  assign adv_i_o = adv_i_reg;
  assign adv_e_o = adv_e_reg;
  assign adv_m_o = adv_m_reg;
  assign adv_a_o = adv_a_reg;
  assign e_bubble_o = bub_reg;
  assign w_we_o = w_v_reg;
  assign w_dst_o = w_d_reg;

  a_load_slip: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RULE6
    (late_hit && adv_m) |-> !adv_e ##1 !m_v_reg)
    else $error("late result consumer not slipped");
  a_hold_order: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RULE12
    !adv_m |-> !adv_e && !adv_i) else $error("younger stage moved past held stage");
  a_bubble_fill: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RULE13
    (adv_m && !adv_e) |=> !m_v_reg) else $error("no bubble after slip");
  a_no_stall: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RULE11
    !dside_slip_i |-> adv_m) else $error("late pipe stalled without cause");
  a_young_wins: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RULE17
    (m_wr && !m_late_reg && a_wr && m_d_reg == a_d_reg && e_sa_reg == m_d_reg)
    |-> sel_a == IPBI_SEL_M) else $error("older producer selected");
  a_zero_ignored: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RULE18
    (e_sa_reg == `IPBI_ZERO_REG) |-> sel_a == IPBI_SEL_FILE)
    else $error("register zero forwarded");
  a_issue_flow: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RULE15
    (!hold_m && !hold_e) |-> adv_e ##1 adv_e_reg) else $error("issue delayed without cause");
  a_mul_delay: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RULE16
    (mul_cnt_reg != 2'h0 && e_v_reg) |-> !adv_e) else $error("multiply successor issued early");
  a_fill_restart: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RULE14
    (fetch_reg == IPBI_FETCH_MISS && icache_fill_i) |=> fetch_reg == IPBI_FETCH_FILL ##1
    fetch_reg == IPBI_FETCH_RUN) else $error("fill did not restart pipeline");
  a_bubble_down: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RULE13
    !adv_m |=> !a_v_reg) else $error("held stage copied into A");
  a_dual_path: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RULE5
    (m_wr && !m_late_reg && a_wr && e_sb_reg == m_d_reg && e_sa_reg == a_d_reg &&
    e_sa_reg != m_d_reg) |-> sel_a == IPBI_SEL_A && sel_b == IPBI_SEL_M)
    else $error("operands not forwarded from both stages");
  a_late_path: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RULE7
    (a_wr && e_sa_reg == a_d_reg && !(m_wr && e_sa_reg == m_d_reg)) |-> sel_a == IPBI_SEL_A)
    else $error("older result not taken from A");
  a_move_slip: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RULE8
    (e_v_reg && e_ua_reg && m_wr && m_late_reg && e_sa_reg == m_d_reg) |->
    !adv_e && sel_a != IPBI_SEL_M) else $error("late result used from M");
  a_w_bypass: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RULE4
    (sel_a == IPBI_SEL_FILE && w_wr && e_sa_reg == w_d_reg) |-> op_a_next == w_data_i)
    else $error("write data not bypassed to read");
endmodule

// File: include/ipbi_map.svh
`ifndef IPBI_MAP_SVH
`define IPBI_MAP_SVH
`define IPBI_REG_BITS        5
`define IPBI_DATA_BITS       32
`define IPBI_ZERO_REG        5'h00
`define IPBI_LOAD_SLIP       2'h1
`define IPBI_MOVE_SLIP       2'h1
`define IPBI_MUL_USE_HALF    2'h2
`define IPBI_MUL_USE_FULL    2'h3
`define IPBI_MUL_NOUSE_HALF  2'h1
`define IPBI_MUL_NOUSE_FULL  2'h2
`define IPBI_UNBYPASSED_GAP  2'h3
`endif

// File: include/ipbi_pkg.sv
package ipbi_pkg;
  typedef logic [4:0]  ipbi_reg_t;
  typedef logic [31:0] ipbi_word_t;
  typedef enum logic [1:0] {
    IPBI_SEL_FILE = 2'h0,
    IPBI_SEL_M    = 2'h1,
    IPBI_SEL_A    = 2'h2
  } ipbi_sel_t;
  typedef enum logic [2:0] {
    IPBI_FETCH_RUN  = 3'b001,
    IPBI_FETCH_MISS = 3'b010,
    IPBI_FETCH_FILL = 3'b100
  } ipbi_fetch_t;
endpackage
